// File: design/fpmc_flash_ctrl.v
/*
 flash program memory control: boot/user code map, control register,
 erase and write sequencing with on-chip timing, security latch.
 assumes a cpu core on sys_clk_in, a flash macro that takes the
 command outputs, and strap pins held steady across reset.
*/
`timescale 1ns/1ps
`include "fpmc_regs.vh"

// What this block does
// - byte write plus page, block and full erase of the flash.
// - byte write runs a fixed 2.5 ms timed cycle.
// - page, block and full erase run a fixed 5 ms timed cycle.
// - erase drives all-ones data so erased bytes read back as ones.
// - security byte is read from the top flash address.
// - external access low maps all user code to external memory.
// - both select bits zero maps user memory over the whole space.
// - plain reset clears select bits; start at zero per access level.
// - strobe and access low, latch high at reset starts in boot rom.
// - select 01 gives user below 63K and boot rom above.
// - select 10 maps like 01; upper bit cleared on user fetch.
// - select 11 maps boot rom over the whole code space.
// - return crossing 63K downward clears both select bits.
// - erase and write start only from boot code above 63K.
// - no flash fetch or read while an erase or write runs.
// - select bits at 7 and 6, read-only high voltage flag at 5.
// - function code in bits 3..0 resets to zero, four valid codes.
// - when secure, only internal code loads codes; others full erase.
// - security active on 50h, latched at reset, cleared when a full erase ends.
module fpmc_flash_ctrl #(
    parameter WRITE_CYCLES = `FPMC_WRITE_TIME_NS / `FPMC_CLK_PERIOD_NS,
    parameter ERASE_CYCLES = `FPMC_ERASE_TIME_NS / `FPMC_CLK_PERIOD_NS,
    parameter CNT_W = 18
) (
    input wire sys_clk_in,
    input wire reset_in,
    input wire program_store_strobe_n_in,
    input wire address_latch_in,
    input wire external_access_select_n_in,
    input wire [7:0] sfr_addr_in,
    input wire sfr_wr_in,
    input wire sfr_rd_in,
    input wire [7:0] sfr_wdata_in,
    output reg [7:0] sfr_rdata_out,
    input wire fetch_req_in,
    input wire [15:0] fetch_addr_in,
    input wire fetch_is_return_in,
    output wire fetch_stall_out,
    output reg [1:0] fetch_target_out,
    input wire data_rd_req_in,
    input wire [15:0] data_rd_addr_in,
    output wire data_rd_stall_out,
    output reg data_rd_denied_out,
    input wire op_start_in,
    input wire [15:0] data_pointer_in,
    input wire [7:0] accumulator_in,
    output reg op_refused_out,
    output reg high_voltage_flag_out,
    output reg [14:0] mem_addr_out,
    output reg [7:0] mem_wdata_out,
    output reg mem_write_out,
    output reg mem_erase_out,
    output reg [1:0] mem_erase_size_out,
    output reg mem_read_out,
    input wire [7:0] mem_rdata_in
);

localparam ST_STRAP = 3'h0;
localparam ST_SECRD = 3'h1;
localparam ST_SECCAP = 3'h2;
localparam ST_IDLE = 3'h3;
localparam ST_OP = 3'h4;

localparam integer WRITE_LAST = WRITE_CYCLES - 1;
localparam integer ERASE_LAST = ERASE_CYCLES - 1;
localparam [CNT_W-1:0] WRITE_LOAD = WRITE_LAST[CNT_W-1:0];
localparam [CNT_W-1:0] ERASE_LOAD = ERASE_LAST[CNT_W-1:0];

// ---------------------------------------------------------------
// strap synchronisers
// ---------------------------------------------------------------
reg [1:0] program_store_strobe_sync;
reg [1:0] ale_sync;
reg [1:0] ea_sync;

// free-running so the pin levels are settled at reset release
always @(posedge sys_clk_in) begin
    program_store_strobe_sync <= {program_store_strobe_sync[0], program_store_strobe_n_in};
    ale_sync <= {ale_sync[0], address_latch_in};
    ea_sync <= {ea_sync[0], external_access_select_n_in};
end

// ---------------------------------------------------------------
// state
// ---------------------------------------------------------------
reg [2:0] state;
reg [1:0] ubs;
reg [3:0] fc;
reg ea_high;
reg secure;
reg [CNT_W-1:0] timer;
reg [3:0] op_code;
reg [1:0] exec_tgt;
reg exec_hi;

wire ready = (state == ST_IDLE);
wire busy = (state == ST_OP);
wire sfr_hit = (sfr_addr_in == `FPMC_CTRL_ADDR);
wire fc_valid = (fc == `FPMC_FC_BYTE) || (fc == `FPMC_FC_PAGE) ||
                (fc == `FPMC_FC_BLOCK) || (fc == `FPMC_FC_FULL);

// ---------------------------------------------------------------
// code map
// ---------------------------------------------------------------
reg in_boot_area;
reg boot_sel;
reg ret_cross;
reg [1:0] tgt;

always @* begin
    in_boot_area = (fetch_addr_in >= `FPMC_BOOT_BORDER);
    ret_cross = fetch_is_return_in && exec_hi && !in_boot_area;
    case (ubs)
        2'h0: boot_sel = 1'b0;
        2'h1: boot_sel = in_boot_area;
        2'h2: boot_sel = in_boot_area;
        default: boot_sel = 1'b1;
    endcase
    // return target already lands in user memory
    if (ret_cross)
        boot_sel = 1'b0;
    // access level picks internal or external
    if (boot_sel) begin
        tgt = `FPMC_TGT_BOOT;
    end else if (!ea_high) begin
        tgt = `FPMC_TGT_EXT;
    end else if (fetch_addr_in < `FPMC_FLASH_TOP) begin
        tgt = `FPMC_TGT_INT;
    end else begin
        tgt = `FPMC_TGT_EXT;
    end
end

// hold flash fetches and reads during init and cycles
assign fetch_stall_out = fetch_req_in && !ready && (tgt == `FPMC_TGT_INT);

wire data_int = ea_high && (data_rd_addr_in < `FPMC_FLASH_TOP);
assign data_rd_stall_out = data_rd_req_in && data_int && !ready;

wire fetch_take = fetch_req_in && !fetch_stall_out && (state != ST_STRAP);

// ---------------------------------------------------------------
// fetch tracking
// ---------------------------------------------------------------
always @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
        fetch_target_out <= `FPMC_TGT_INT;
        exec_tgt <= `FPMC_TGT_INT;
        exec_hi <= 1'b0;
        data_rd_denied_out <= 1'b0;
    end else begin
        // map from select value held before this cycle's write
        if (fetch_take) begin
            fetch_target_out <= tgt;
            exec_tgt <= tgt;
            exec_hi <= in_boot_area;
        end
        // external or boot code may not read secured flash
        data_rd_denied_out <= data_rd_req_in && data_int && ready &&
                              secure && (exec_tgt != `FPMC_TGT_INT);
    end
end

// ---------------------------------------------------------------
// control register and sequencer
// ---------------------------------------------------------------
reg [3:0] fc_wr;
reg [1:0] next_ubs;

always @* begin
    // when secured, external or boot code loads only the full erase code
    if (secure && (exec_tgt != `FPMC_TGT_INT) &&
        (sfr_wdata_in[`FPMC_FC_MSB:0] != `FPMC_FC_FULL)) begin
        fc_wr = fc;
    end else begin
        fc_wr = sfr_wdata_in[`FPMC_FC_MSB:0];
    end
    next_ubs = ubs;
    // upper bit dropped on a user-range fetch
    if (fetch_take && (ubs == 2'h2) && !in_boot_area) begin
        next_ubs = 2'h0;
    end
    // border crossing by a return clears both
    if (fetch_take && ret_cross) begin
        next_ubs = 2'h0;
    end
    if (sfr_wr_in && sfr_hit) begin
        next_ubs = sfr_wdata_in[`FPMC_UPPER_BOOT_SELECT_BIT:`FPMC_LOWER_BOOT_SELECT_BIT];
    end
end

always @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
        state <= ST_STRAP;
        ubs <= `FPMC_UBS_RESET;
        fc <= `FPMC_FC_RESET;
        ea_high <= 1'b0;
        secure <= 1'b0;
        timer <= {CNT_W{1'b0}};
        op_code <= `FPMC_FC_RESET;
        op_refused_out <= 1'b0;
        high_voltage_flag_out <= 1'b0;
        mem_addr_out <= 15'h0000;
        mem_wdata_out <= 8'h00;
        mem_write_out <= 1'b0;
        mem_erase_out <= 1'b0;
        mem_erase_size_out <= 2'h0;
        mem_read_out <= 1'b0;
        sfr_rdata_out <= 8'h00;
    end else begin
        op_refused_out <= 1'b0;
        // fields at 7..6, flag at 5, reserved reads zero
        if (sfr_rd_in && sfr_hit) begin
            sfr_rdata_out <= {ubs, high_voltage_flag_out, 1'b0, fc};
        end else begin
            sfr_rdata_out <= 8'h00;
        end
        if (state != ST_STRAP)
            ubs <= next_ubs;
        if (sfr_wr_in && sfr_hit && !busy) begin
            fc <= fc_wr;
        end
        case (state)
            ST_STRAP: begin
                ea_high <= ea_sync[1];
                if (!program_store_strobe_sync[1] && !ea_sync[1] && ale_sync[1]) begin
                    ubs <= `FPMC_UBS_BOOT;
                end else begin
                    ubs <= `FPMC_UBS_RESET;
                end
                state <= ST_SECRD;
            end
            ST_SECRD: begin
                mem_addr_out <= `FPMC_SEC_ADDR;
                mem_read_out <= 1'b1;
                state <= ST_SECCAP;
            end
            ST_SECCAP: begin
                if (mem_read_out) begin
                    mem_read_out <= 1'b0;
                end else begin
                    secure <= (mem_rdata_in == `FPMC_SEC_ON);
                    state <= ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (op_start_in) begin
                    // only boot code above the border
                    if ((exec_tgt == `FPMC_TGT_BOOT) && exec_hi && fc_valid) begin
                        state <= ST_OP;
                        op_code <= fc;
                        high_voltage_flag_out <= 1'b1;
                        case (fc)
                            `FPMC_FC_PAGE: begin
                                mem_addr_out <= data_pointer_in[14:0] & `FPMC_PAGE_MASK;
                                mem_erase_size_out <= `FPMC_SZ_PAGE;
                            end
                            `FPMC_FC_BLOCK: begin
                                mem_addr_out <= data_pointer_in[14:0] & `FPMC_BLOCK_MASK;
                                mem_erase_size_out <= `FPMC_SZ_BLOCK;
                            end
                            `FPMC_FC_FULL: begin
                                mem_addr_out <= `FPMC_FULL_MASK;
                                mem_erase_size_out <= `FPMC_SZ_FULL;
                            end
                            default: begin
                                mem_addr_out <= data_pointer_in[14:0];
                                mem_erase_size_out <= 2'h0;
                            end
                        endcase
                        if (fc == `FPMC_FC_BYTE) begin
                            timer <= WRITE_LOAD;
                            mem_write_out <= 1'b1;
                            mem_wdata_out <= accumulator_in;
                        end else begin
                            timer <= ERASE_LOAD;
                            mem_erase_out <= 1'b1;
                            mem_wdata_out <= `FPMC_ERASED;
                        end
                    end else begin
                        op_refused_out <= 1'b1;
                    end
                end
            end
            ST_OP: begin
                if (op_start_in)
                    op_refused_out <= 1'b1;
                if (timer == {CNT_W{1'b0}}) begin
                    state <= ST_IDLE;
                    high_voltage_flag_out <= 1'b0;
                    mem_write_out <= 1'b0;
                    mem_erase_out <= 1'b0;
                    mem_erase_size_out <= 2'h0;
                    // full erase wipes the security byte too
                    if (op_code == `FPMC_FC_FULL) begin
                        secure <= 1'b0;
                    end
                end else begin
                    timer <= timer - 1'b1;
                end
            end
            default: begin
                state <= ST_IDLE;
            end
        endcase
    end
end

endmodule

// File: design/fpmc_regs.vh
/*
 flash program memory control: register offset, field positions,
 reset values, function codes, map borders and operation times.
 assumes inclusion by bare name from the control module.
*/
`ifndef FPMC_REGS_VH
`define FPMC_REGS_VH
`define FPMC_CTRL_ADDR 8'hFB
`define FPMC_UPPER_BOOT_SELECT_BIT 7
`define FPMC_LOWER_BOOT_SELECT_BIT 6
`define FPMC_HV_BIT 5
`define FPMC_RSVD_BIT 4
`define FPMC_FC_MSB 3
`define FPMC_UBS_RESET 2'h0
`define FPMC_UBS_BOOT 2'h3
`define FPMC_FC_RESET 4'h0
`define FPMC_FC_BYTE 4'h5
`define FPMC_FC_PAGE 4'hC
`define FPMC_FC_BLOCK 4'h3
`define FPMC_FC_FULL 4'hA
`define FPMC_BOOT_BORDER 16'hFC00
`define FPMC_FLASH_TOP 16'h8000
`define FPMC_SEC_ADDR 15'h7FFF
`define FPMC_SEC_ON 8'h50
`define FPMC_ERASED 8'hFF
`define FPMC_PAGE_MASK 15'h7FE0
`define FPMC_BLOCK_MASK 15'h7F00
`define FPMC_FULL_MASK 15'h0000
`define FPMC_SZ_PAGE 2'h1
`define FPMC_SZ_BLOCK 2'h2
`define FPMC_SZ_FULL 2'h3
`define FPMC_TGT_INT 2'h0
`define FPMC_TGT_EXT 2'h1
`define FPMC_TGT_BOOT 2'h2
`define FPMC_CLK_PERIOD_NS 20
`define FPMC_WRITE_TIME_NS 2500000
`define FPMC_ERASE_TIME_NS 5000000
`endif

// File: testbench/fpmc_ctrl_properties.sv
/*
 port checker for the flash program memory control block.
 assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/1ps
module fpmc_ctrl_chk #(
    parameter WRITE_CYCLES = 20,
    parameter ERASE_CYCLES = 40
) (
    input wire sys_clk_in,
    input wire reset_in,
    input wire external_access_select_n_in,
    input wire [7:0] sfr_addr_in,
    input wire sfr_rd_in,
    input wire [7:0] sfr_rdata_out,
    input wire data_rd_req_in,
    input wire [15:0] data_rd_addr_in,
    input wire data_rd_stall_out,
    input wire op_start_in,
    input wire op_refused_out,
    input wire high_voltage_flag_out,
    input wire [14:0] mem_addr_out,
    input wire [7:0] mem_wdata_out,
    input wire mem_write_out,
    input wire mem_erase_out,
    input wire [1:0] mem_erase_size_out,
    input wire mem_read_out
);
    // -------------------------
    // high voltage cycle count
    // -------------------------
    integer hv_cnt;
    always @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in)
            hv_cnt <= 0;
        else
            hv_cnt <= high_voltage_flag_out ? hv_cnt + 1 : 0;
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);
    property p_rd_idle;
        !(sfr_rd_in && sfr_addr_in == 8'hFB) |=> sfr_rdata_out == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("idle read data");
    property p_rd_fields;
        sfr_rd_in && sfr_addr_in == 8'hFB |=>
            sfr_rdata_out[5:4] == {$past(high_voltage_flag_out), 1'b0};
    endproperty
    a_rd_fields: assert property (p_rd_fields) else $error("flag bits");
    property p_hv_mem;
        high_voltage_flag_out == (mem_write_out || mem_erase_out);
    endproperty
    a_hv_mem: assert property (p_hv_mem) else $error("flag vs cycle");
    property p_erase_ff;
        mem_erase_out |-> mem_wdata_out == 8'hFF && mem_erase_size_out != 2'h0;
    endproperty
    a_erase_ff: assert property (p_erase_ff) else $error("erase data");
    property p_align;
        mem_erase_out |-> (mem_erase_size_out == 2'h1 && mem_addr_out[4:0] == 5'h00)
            || (mem_erase_size_out == 2'h2 && mem_addr_out[7:0] == 8'h00)
            || (mem_erase_size_out == 2'h3 && mem_addr_out == 15'h0000);
    endproperty
    a_align: assert property (p_align) else $error("erase alignment");
    property p_op_len;
        $fell(high_voltage_flag_out) |->
            hv_cnt == ($past(mem_write_out) ? WRITE_CYCLES : ERASE_CYCLES);
    endproperty
    a_op_len: assert property (p_op_len) else $error("cycle length");
    property p_busy_refuse;
        op_start_in && high_voltage_flag_out |=> op_refused_out;
    endproperty
    a_busy_refuse: assert property (p_busy_refuse) else $error("busy start");
    property p_flash_stall;
        high_voltage_flag_out && data_rd_req_in && !data_rd_addr_in[15]
            && external_access_select_n_in |-> data_rd_stall_out;
    endproperty
    a_flash_stall: assert property (p_flash_stall) else $error("no stall");
    property p_sec_read;
        mem_read_out |-> mem_addr_out == 15'h7FFF;
    endproperty
    a_sec_read: assert property (p_sec_read) else $error("security read address");
    c_write: cover property ($rose(mem_write_out));
    c_erase: cover property ($rose(mem_erase_out));
    c_refuse: cover property (op_refused_out);
endmodule
bind fpmc_flash_ctrl fpmc_ctrl_chk #(.WRITE_CYCLES(WRITE_CYCLES),
    .ERASE_CYCLES(ERASE_CYCLES)) chk (.sys_clk_in, .reset_in, .external_access_select_n_in,
    .sfr_addr_in, .sfr_rd_in, .sfr_rdata_out, .data_rd_req_in, .data_rd_addr_in,
    .data_rd_stall_out, .op_start_in, .op_refused_out, .high_voltage_flag_out, .mem_addr_out,
    .mem_wdata_out, .mem_write_out, .mem_erase_out, .mem_erase_size_out, .mem_read_out);

// File: testbench/fpmc_flash_model.sv
/*
 flash macro model answering the start-up security read.
 assumes data is sampled two cycles after the read pulse.
*/
`timescale 1ns/1ps
module fpmc_flash_model (
    input wire clk_in,
    input wire read_in,
    input wire [14:0] addr_in,
    input wire [7:0] sec_in,
    output wire [7:0] rdata_out
);
    reg [1:0] age = 2'h0;
    reg hit = 1'b0;
    reg tog = 1'b0;
    always @(posedge clk_in) begin
        tog <= ~tog;
        if (read_in) begin
            age <= 2'h3;
            hit <= addr_in == 15'h7FFF;
        end else if (age != 2'h0)
            age <= age - 2'h1;
    end
    assign rdata_out = (age != 2'h0 && hit) ? sec_in : {8{tog}};
endmodule

// File: testbench/tb.sv
/*
 self-checking bench for the flash program memory control block.
 assumes the checker and the flash model are compiled first.
*/
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
    $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module tb;
    localparam WC = 20;
    localparam EC = 40;
    reg sys_clk_in = 0, reset_in = 1, program_store_strobe_n_in = 1, address_latch_in = 1;
    reg external_access_select_n_in = 1, sfr_wr_in = 0, sfr_rd_in = 0, fetch_req_in = 0;
    reg fetch_is_return_in = 0, data_rd_req_in = 0, op_start_in = 0;
    reg [7:0] sfr_addr_in = 0, sfr_wdata_in = 0, accumulator_in = 0, sec = 0, v;
    reg [15:0] fetch_addr_in = 0, data_rd_addr_in = 0, data_pointer_in = 0, codes = 16'h5C3A;
    reg [1:0] u;
    wire [7:0] sfr_rdata_out, mem_wdata_out, mem_rdata_in;
    wire [1:0] fetch_target_out, mem_erase_size_out;
    wire [14:0] mem_addr_out;
    wire fetch_stall_out, data_rd_stall_out, data_rd_denied_out, op_refused_out;
    wire high_voltage_flag_out, mem_write_out, mem_erase_out, mem_read_out;
    integer miscompares = 0, checks_done = 0, i;
    always #10 sys_clk_in = ~sys_clk_in;
    fpmc_flash_ctrl #(.WRITE_CYCLES(WC), .ERASE_CYCLES(EC)) uut (.sys_clk_in, .reset_in,
        .program_store_strobe_n_in, .address_latch_in, .external_access_select_n_in,
        .sfr_addr_in, .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in, .sfr_rdata_out, .fetch_req_in,
        .fetch_addr_in, .fetch_is_return_in, .fetch_stall_out, .fetch_target_out,
        .data_rd_req_in, .data_rd_addr_in, .data_rd_stall_out, .data_rd_denied_out,
        .op_start_in, .data_pointer_in, .accumulator_in, .op_refused_out, .high_voltage_flag_out,
        .mem_addr_out, .mem_wdata_out, .mem_write_out, .mem_erase_out, .mem_erase_size_out,
        .mem_read_out, .mem_rdata_in);
    fpmc_flash_model fm (.clk_in(sys_clk_in), .read_in(mem_read_out), .addr_in(mem_addr_out),
        .sec_in(sec), .rdata_out(mem_rdata_in));
    // ----------------------
    // expectations and bus
    // ----------------------
    function [1:0] exp_tgt(input [1:0] s, input [15:0] a);
        exp_tgt = (s == 2'h3 || (s != 2'h0 && a >= 16'hFC00)) ? 2'h2 : {1'b0, a[15]};
    endfunction
    function [14:0] exp_addr(input [3:0] c, input [14:0] d);
        exp_addr = c == 4'hC ? d & 15'h7FE0 : c == 4'h3 ? d & 15'h7F00 : c == 4'hA ? 15'h0 : d;
    endfunction
    function [1:0] exp_sz(input [3:0] c);
        exp_sz = c == 4'hC ? 2'h1 : c == 4'h3 ? 2'h2 : c == 4'hA ? 2'h3 : 2'h0;
    endfunction
    task summarize;
        begin
            $display("checks %0d miscompares %0d", checks_done, miscompares);
            if (miscompares == 0 && checks_done > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task do_reset(input p, input e, input [7:0] s);
        begin
            reset_in <= 1;
            program_store_strobe_n_in <= p;
            external_access_select_n_in <= e;
            sec <= s;
            repeat (2) @(posedge sys_clk_in);
            reset_in <= 0;
            repeat (5) @(posedge sys_clk_in);
        end
    endtask
    task rd(input [7:0] a, input [7:0] e);
        begin
            @(posedge sys_clk_in) sfr_addr_in <= a;
            sfr_rd_in <= 1;
            @(posedge sys_clk_in) sfr_rd_in <= 0;
            #1 `CHK("rdata", e, sfr_rdata_out);
        end
    endtask
    task wr(input [7:0] d);
        begin
            @(posedge sys_clk_in) sfr_addr_in <= 8'hFB;
            sfr_wdata_in <= d;
            sfr_wr_in <= 1;
            @(posedge sys_clk_in) sfr_wr_in <= 0;
        end
    endtask
    task fetch(input [15:0] a, input r, input [1:0] e);
        begin
            @(posedge sys_clk_in) fetch_req_in <= 1;
            fetch_addr_in <= a;
            fetch_is_return_in <= r;
            @(posedge sys_clk_in) fetch_req_in <= 0;
            fetch_is_return_in <= 0;
            #1 `CHK("target", e, fetch_target_out);
        end
    endtask
    task drd(input [15:0] a, input e);
        begin
            @(posedge sys_clk_in) data_rd_req_in <= 1;
            data_rd_addr_in <= a;
            @(posedge sys_clk_in) data_rd_req_in <= 0;
            #1 `CHK("denied", e, data_rd_denied_out);
        end
    endtask
    task op(input [3:0] c, input ok, input [15:0] fa);
        reg [14:0] d;
        begin
            d = 15'($urandom);
            wr({4'h4, c});
            fetch(fa, 0, exp_tgt(2'h1, fa));
            @(posedge sys_clk_in) data_pointer_in <= {1'b0, d};
            accumulator_in <= 8'($urandom);
            op_start_in <= 1;
            @(posedge sys_clk_in) op_start_in <= 0;
            #1 `CHK("hv", ok, high_voltage_flag_out);
            if (!ok) begin
                `CHK("refused", 1'b1, op_refused_out);
            end else begin
                `CHK("write", c == 4'h5, mem_write_out);
                `CHK("erase", c != 4'h5, mem_erase_out);
                `CHK("size", exp_sz(c), mem_erase_size_out);
                `CHK("addr", exp_addr(c, d), mem_addr_out);
                `CHK("wdata", c == 4'h5 ? accumulator_in : 8'hFF, mem_wdata_out);
                @(posedge sys_clk_in) op_start_in <= 1;
                data_rd_req_in <= 1;
                data_rd_addr_in <= {1'b0, d};
                fetch_req_in <= 1;
                fetch_addr_in <= {1'b0, d};
                #1 `CHK("stall", 1'b1, data_rd_stall_out);
                `CHK("fstall", 1'b1, fetch_stall_out);
                @(posedge sys_clk_in) op_start_in <= 0;
                data_rd_req_in <= 0;
                fetch_req_in <= 0;
                #1 `CHK("refused", 1'b1, op_refused_out);
                repeat ((c == 4'h5 ? WC : EC) - 3) @(posedge sys_clk_in);
                #1 `CHK("hv", 1'b1, high_voltage_flag_out);
                @(posedge sys_clk_in) #1 `CHK("hv", 1'b0, high_voltage_flag_out);
            end
        end
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        miscompares++;
        summarize;
    end
    initial begin
        void'($urandom(82312));
        do_reset(1, 1, 8'hFF);
        rd(8'hFB, 8'h00);
        rd(8'hFA, 8'h00);
        for (i = 0; i < 4; i++) begin
            v = 8'($urandom) & 8'hEF;
            wr(v);
            rd(8'hFB, v & 8'hCF);
        end
        for (i = 0; i < 4; i++) begin
            u = i[1:0];
            wr({u, 6'h00});
            fetch(16'hFC10, 0, exp_tgt(u, 16'hFC10));
            fetch(16'h0100, 0, exp_tgt(u, 16'h0100));
            rd(8'hFB, u == 2'h2 ? 8'h00 : {u, 6'h00});
        end
        wr(8'h40);
        fetch(16'hFFAA, 0, 2'h2);
        fetch(16'h0200, 1, 2'h0);
        rd(8'hFB, 8'h00);
        for (i = 0; i < 4; i++)
            op(codes[15 - 4 * i -: 4], 1, 16'hFFAA);
        op(4'h0, 0, 16'hFFAA);
        op(4'h7, 0, 16'hFFAA);
        op(4'h5, 0, 16'h0100);
        do_reset(0, 0, 8'h50);
        rd(8'hFB, 8'hC0);
        fetch(16'h0100, 0, 2'h2);
        wr(8'hC5);
        rd(8'hFB, 8'hC0);
        wr(8'hCA);
        rd(8'hFB, 8'hCA);
        wr(8'h0A);
        fetch(16'h0100, 0, 2'h1);
        do_reset(1, 1, 8'h50);
        rd(8'hFB, 8'h00);
        fetch(16'hFFAA, 0, 2'h1);
        drd(16'h0100, 1'b1);
        fetch(16'h0100, 0, 2'h0);
        drd(16'h0100, 1'b0);
        summarize;
    end
endmodule
